// ### rtl/dac_control_defines.vh
// Constants for the converter control register block
`ifndef DAC_CONTROL_DEFINES_VH
`define DAC_CONTROL_DEFINES_VH

// Special-function addresses
`define ADDR_DATA_LOW    8'hfb
`define ADDR_DATA_HIGH   8'hfc
`define ADDR_CONTROL     8'hfd

// Reset values
`define RESET_BYTE       8'h00
`define RESET_WORD       12'h000
`define SEL_RESET        1'b0

// Control bit positions
`define BIT_PIN_SELECT   4
`define BIT_NARROW       3
`define BIT_RANGE        2
`define BIT_CLEAR_N      1
`define BIT_ENABLE       0

// Writable control bits; the upper three are reserved and read zero
`define CONTROL_MASK     8'h1f

// Field widths
`define NIBBLE_ZERO      4'h0
`define HIGH_NIBBLE_MSB  3

`endif

// ### rtl/dac_word_format.v
// Combinational formatting of the converter input word
`timescale 1ns/1ps
module dac_word_format (
   // Register contents
   input  wire [7:0]  data_low,
   input  wire [7:0]  data_high,
   // Mode
   input  wire        narrow_mode,
   // Formatted word
   output wire [11:0] word
);
`include "dac_control_defines.vh"

   // Narrow mode puts the low byte on the top bits, right-justified otherwise
   assign word = narrow_mode ? {data_low, `NIBBLE_ZERO}
                             : {data_high[`HIGH_NIBBLE_MSB:0], data_low};

endmodule

// ### rtl/dac_control_regs.v
// Register file and update logic for the on-chip voltage-output converter
//
// Notes on behaviour
// - In 12-bit mode the output word loads only on a low-byte write.
// - Narrow mode: low byte drives top eight bits, bottom four bits zero.
// - Control bit 4 routes output to the alternate pin when set.
// - Control bit 2 selects supply range when set, internal reference when clear.
// - Control bit 1 low holds both data registers at zero.
// - Control bit 0 low powers the converter down.
// - Control bits 7 to 5 are reserved and have no function.
// - In 12-bit mode data is right-justified: low byte bits 7..0, high nibble bits 11..8.
// - Reset clears control and both data registers to zero.
`timescale 1ns/1ps
module dac_control_regs (
   // Clock and reset
   input  wire        clk_sys,
   input  wire        reset_n,
   // Special-function register port
   input  wire [7:0]  sfr_addr,
   input  wire        sfr_wr,
   input  wire        sfr_rd,
   input  wire [7:0]  sfr_wdata,
   output reg  [7:0]  sfr_rdata,
   output reg         sfr_sel,
   // Converter controls
   output reg  [11:0] converter_word,
   output reg         output_pin_select,
   output reg         range_select,
   output reg         power_down,
   output reg         narrow_mode
);
`include "dac_control_defines.vh"

   // Stored registers
   reg  [7:0]  converter_data_low_r;
   reg  [7:0]  converter_data_high_r;
   reg  [7:0]  converter_control_r;
   reg  [7:0]  converter_data_low_nxt;
   reg  [7:0]  converter_data_high_nxt;
   reg  [7:0]  converter_control_nxt;
   reg  [11:0] converter_word_nxt;
   reg  [7:0]  rdata_nxt;

   wire        hit_low;
   wire        hit_high;
   wire        hit_ctrl;
   wire        clear_n_nxt;
   wire [11:0] formatted;
   wire        wr_low;
   wire        wr_high;
   wire        wr_ctrl;
   wire        read_hit;
   wire [7:0]  control_mask;
   wire [7:0]  control_write;
   wire [7:0]  control_reset;
   genvar      gi;

   // Address decode, used for both reads and writes
   function match;
      input [7:0] addr;
      input [7:0] target;
      begin
         match = (addr == target);
      end
   endfunction

   assign hit_low  = match(sfr_addr, `ADDR_DATA_LOW);
   assign hit_high = match(sfr_addr, `ADDR_DATA_HIGH);
   assign hit_ctrl = match(sfr_addr, `ADDR_CONTROL);

   // One strobe per register keeps the decode in a single place
   assign wr_low   = sfr_wr & hit_low;
   assign wr_high  = sfr_wr & hit_high;
   assign wr_ctrl  = sfr_wr & hit_ctrl;
   assign read_hit = sfr_rd & (hit_low | hit_high | hit_ctrl);

   // Writable mask and reset image of the control register
   assign control_mask  = `CONTROL_MASK;
   assign control_reset = `RESET_BYTE;

   // Per-bit write gating; reserved positions can never hold a one
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_ctrl_bit
         assign control_write[gi] = sfr_wdata[gi] & control_mask[gi];
      end
   endgenerate

   // Next control value; reserved bits never store
   always @* begin
      converter_control_nxt = converter_control_r;
      if (wr_ctrl) begin
         converter_control_nxt = control_write;
      end
   end

   assign clear_n_nxt = converter_control_nxt[`BIT_CLEAR_N];

   // Data registers; a clear in effect overrides any write in the same cycle
   always @* begin
      converter_data_low_nxt  = converter_data_low_r;
      converter_data_high_nxt = converter_data_high_r;
      if (wr_low) begin
         converter_data_low_nxt = sfr_wdata;
      end
      if (wr_high) begin
         converter_data_high_nxt = sfr_wdata;
      end
      if (!clear_n_nxt) begin
         converter_data_low_nxt  = `RESET_BYTE;
         converter_data_high_nxt = `RESET_BYTE;
      end
   end

   // Word as it would appear from the new register contents
   dac_word_format u_format (
      .data_low    (converter_data_low_nxt),
      .data_high   (converter_data_high_nxt),
      .narrow_mode (converter_control_nxt[`BIT_NARROW]),
      .word        (formatted)
   );

   // Output word loads on a low-byte write; a clear also zeroes it at once
   always @* begin
      converter_word_nxt = converter_word;
      if (wr_low) begin
         converter_word_nxt = formatted;
      end
      if (!clear_n_nxt) begin
         converter_word_nxt = `RESET_WORD;
      end
   end

   // Read mux; unmapped addresses read zero and do not claim the bus
   always @* begin
      rdata_nxt = `RESET_BYTE;
      if (sfr_rd && hit_low) begin
         rdata_nxt = converter_data_low_r;
      end else if (sfr_rd && hit_high) begin
         rdata_nxt = converter_data_high_r;
      end else if (sfr_rd && hit_ctrl) begin
         rdata_nxt = converter_control_r;
      end
   end

   // Low data byte
   always @(posedge clk_sys) begin
      if (!reset_n) begin
         converter_data_low_r <= `RESET_BYTE;
      end else begin
         converter_data_low_r <= converter_data_low_nxt;
      end
   end

   // High data byte; upper nibble is kept for readback only
   always @(posedge clk_sys) begin
      if (!reset_n) begin
         converter_data_high_r <= `RESET_BYTE;
      end else begin
         converter_data_high_r <= converter_data_high_nxt;
      end
   end

   // Control register
   always @(posedge clk_sys) begin
      if (!reset_n) begin
         converter_control_r <= `RESET_BYTE;
      end else begin
         converter_control_r <= converter_control_nxt;
      end
   end

   // Converter word; reset agrees with the cleared data registers
   always @(posedge clk_sys) begin
      if (!reset_n) begin
         converter_word <= `RESET_WORD;
      end else begin
         converter_word <= converter_word_nxt;
      end
   end

   // Output routing; alternate pin when set
   always @(posedge clk_sys) begin
      if (!reset_n) begin
         output_pin_select <= control_reset[`BIT_PIN_SELECT];
      end else begin
         output_pin_select <= converter_control_nxt[`BIT_PIN_SELECT];
      end
   end

   // Output range; supply when set, internal reference when clear
   always @(posedge clk_sys) begin
      if (!reset_n) begin
         range_select <= control_reset[`BIT_RANGE];
      end else begin
         range_select <= converter_control_nxt[`BIT_RANGE];
      end
   end

   // Power-down is the inverse of the enable bit, so reset starts powered down
   always @(posedge clk_sys) begin
      if (!reset_n) begin
         power_down <= ~control_reset[`BIT_ENABLE];
      end else begin
         power_down <= ~converter_control_nxt[`BIT_ENABLE];
      end
   end

   // Narrow flag from the next value, so it moves on the write edge itself
   always @(posedge clk_sys) begin
      if (!reset_n) begin
         narrow_mode <= control_reset[`BIT_NARROW];
      end else begin
         narrow_mode <= converter_control_nxt[`BIT_NARROW];
      end
   end

   // Read port; data and select stand one cycle, then fall back to zero
   always @(posedge clk_sys) begin
      if (!reset_n) begin
         sfr_rdata <= `RESET_BYTE;
         sfr_sel   <= `SEL_RESET;
      end else begin
         sfr_rdata <= rdata_nxt;
         sfr_sel   <= read_hit;
      end
   end

endmodule

// ### verification/dac_control_monitor.sv
// Checker for the converter control register block
`timescale 1ns/1ps
module dac_control_monitor (
   // Clock, reset and register port
   input wire        clk_sys, reset_n, sfr_wr, sfr_rd, sfr_sel,
   input wire [7:0]  sfr_addr, sfr_wdata, sfr_rdata,
   // Converter controls
   input wire [11:0] converter_word,
   input wire        output_pin_select, range_select, power_down, narrow_mode
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   // Decoded strobes
   wire wl = sfr_wr && sfr_addr == 8'hfb;
   wire wh = sfr_wr && sfr_addr == 8'hfc;
   wire wc = sfr_wr && sfr_addr == 8'hfd;
   wire hit = sfr_addr >= 8'hfb && sfr_addr <= 8'hfd;
   // Clear bit and high byte as software last left them
   reg       clear_n_seen;
   reg [7:0] high_seen;
   always @(posedge clk_sys) begin
      if (!reset_n) begin
         clear_n_seen <= 1'b0;
         high_seen    <= 8'h00;
      end else begin
         if (wc) clear_n_seen <= sfr_wdata[1];
         if (wc && !sfr_wdata[1]) high_seen <= 8'h00;
         else if (wh && clear_n_seen) high_seen <= sfr_wdata;
      end
   end
   chk_high_hold: assert property (wh |=> $stable(converter_word))
      else $error("high byte write moved the word");
   chk_wide_word: assert property (wl && !narrow_mode && clear_n_seen |=> converter_word == {$past(high_seen[3:0]), $past(sfr_wdata)})
      else $error("wide word wrong");
   chk_narrow_word: assert property (wl && narrow_mode && clear_n_seen |=> converter_word == {$past(sfr_wdata), 4'h0})
      else $error("narrow word wrong");
   chk_clear_holds: assert property (!clear_n_seen |-> converter_word == 12'h000)
      else $error("word not cleared");
   chk_pin_route: assert property (wc |=> output_pin_select == $past(sfr_wdata[4]))
      else $error("pin select wrong");
   chk_range_bit: assert property (wc |=> range_select == $past(sfr_wdata[2]))
      else $error("range wrong");
   chk_power_ctl: assert property (wc |=> power_down == !$past(sfr_wdata[0]))
      else $error("power down wrong");
   chk_ctrl_read: assert property (sfr_rd && sfr_addr == 8'hfd |=> sfr_rdata[7:5] == 3'h0 && sfr_rdata[4] == output_pin_select)
      else $error("control readback wrong");
   chk_addr_map: assert property (sfr_rd |=> sfr_sel == $past(hit) ##1 sfr_rdata == 8'h00)
      else $error("read select wrong");
   chk_reset_state: assert property ($rose(reset_n) |-> power_down && !converter_word && !narrow_mode)
      else $error("reset state wrong");
   // Main scenarios reached
   cov_narrow: cover property (wl && narrow_mode);
   cov_ctrl_rd: cover property (sfr_rd && sfr_addr == 8'hfd);
   cov_unmapped: cover property (sfr_rd && !hit);
endmodule

// ### verification/tb.sv
// Self-checking bench for the converter control registers
`timescale 1ns/1ps
module tb;
   reg         clk_sys = 0, reset_n = 0, sfr_wr = 0, sfr_rd = 0;
   reg  [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00;
   wire [7:0]  sfr_rdata;
   wire [11:0] converter_word;
   wire        sfr_sel, output_pin_select, range_select, power_down, narrow_mode;
   integer     bad_count = 0, n_tests = 0;
   always #25 clk_sys = ~clk_sys;
   dac_control_regs u_dac_control_regs (.clk_sys(clk_sys), .reset_n(reset_n), .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_sel(sfr_sel),
      .converter_word(converter_word), .output_pin_select(output_pin_select),
      .range_select(range_select), .power_down(power_down), .narrow_mode(narrow_mode));
   task check(input string n, input [11:0] s, e);
      n_tests++;
      if (s !== e) begin
         bad_count++;
         $display("mismatch %0s expected %h seen %h", n, e, s);
      end
   endtask
   // One write cycle; outputs have landed when this returns
   task wr(input [7:0] a, d);
      @(posedge clk_sys); #1 sfr_addr = a; sfr_wdata = d; sfr_wr = 1;
      @(posedge clk_sys); #1 sfr_wr = 0;
   endtask
   // Read data stands only one cycle, so it is judged at once
   task rd(input [7:0] a, e, input sel);
      @(posedge clk_sys); #1 sfr_addr = a; sfr_rd = 1;
      @(posedge clk_sys); #1 sfr_rd = 0;
      check("rdata", sfr_rdata, e);
      check("sel", sfr_sel, sel);
   endtask
   task t_reset;
      rd(8'hfb, 8'h00, 1); rd(8'hfc, 8'h00, 1); rd(8'hfd, 8'h00, 1);
      check("pdn", power_down, 1);
      rd(8'hfe, 8'h00, 0);
   endtask
   task t_ctrl;
      wr(8'hfd, 8'hff); rd(8'hfd, 8'h1f, 1);
      check("pin", output_pin_select, 1); check("rng", range_select, 1);
      check("pdn", power_down, 0); check("nar", narrow_mode, 1);
      wr(8'hfd, 8'h02); check("pdn", power_down, 1); check("pin", output_pin_select, 0);
      check("rng", range_select, 0);
      check("nar", narrow_mode, 0);
   endtask
   task t_wide;
      wr(8'hfd, 8'h03); wr(8'hfc, 8'hab); check("word", converter_word, 12'h000);
      wr(8'hfb, 8'hcd); check("word", converter_word, 12'hbcd);
      rd(8'hfc, 8'hab, 1);
   endtask
   task t_narrow;
      wr(8'hfd, 8'h0b); wr(8'hfb, 8'h5a); check("word", converter_word, 12'h5a0);
      wr(8'hfc, 8'h07); check("word", converter_word, 12'h5a0);
   endtask
   task t_clear;
      wr(8'hfd, 8'h01); check("word", converter_word, 12'h000);
      wr(8'hfb, 8'h77); rd(8'hfb, 8'h00, 1); rd(8'hfc, 8'h00, 1);
      wr(8'hfd, 8'h03); wr(8'hfb, 8'h12); check("word", converter_word, 12'h012);
   endtask
   // Reset again in mid-run, with every writable control bit (4 to 0) set
   task t_reset_again;
      wr(8'hfd, 8'h1f); @(posedge clk_sys); #1 reset_n = 0;
      repeat (2) @(posedge clk_sys); #1 reset_n = 1;
      check("pdn", power_down, 1); check("word", converter_word, 12'h000);
      check("nar", narrow_mode, 0); rd(8'hfd, 8'h00, 1);
   endtask
   task summarize;
      if (bad_count == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Watchdog well beyond the expected run
   initial begin
      #100000 bad_count++;
      summarize;
   end
   initial begin
      repeat (10) @(posedge clk_sys);
      #1 reset_n = 1;
      t_reset; t_ctrl; t_wide; t_narrow; t_clear; t_reset_again;
      summarize;
   end
endmodule
bind dac_control_regs dac_control_monitor u_dac_control_monitor (.*);
